// [src/drs_pkg.sv]
package drs_pkg;

   localparam int ADDR_W = 32;
   localparam int CNT_W = 32;
   localparam int SEL_W = 5;
   localparam int EVT_W = 18;

   // event select codes
   localparam logic [4:0] EVT_NONE = 5'h00;
   localparam logic [4:0] EVT_TIMER0 = 5'h01;
   localparam logic [4:0] EVT_TIMER1 = 5'h02;
   localparam logic [4:0] EVT_REFRESH = 5'h03;
   localparam logic [4:0] EVT_PIN4 = 5'h04;
   localparam logic [4:0] EVT_PIN7 = 5'h07;
   localparam logic [4:0] EVT_CH0 = 5'h08;
   localparam logic [4:0] EVT_CH3 = 5'h0B;
   localparam logic [4:0] EVT_SER0_TX = 5'h0C;
   localparam logic [4:0] EVT_SER1_RX = 5'h0F;
   localparam logic [4:0] EVT_HOST = 5'h10;
   localparam logic [4:0] EVT_SER2_TX = 5'h11;
   localparam logic [4:0] EVT_SER2_RX = 5'h12;
   localparam logic [4:0] EVT_LAST = 5'h12;

   // run-control values
   localparam logic [1:0] RUN_STOP = 2'h0;
   localparam logic [1:0] RUN_AUTO = 2'h3;

   // reload select encodings
   localparam logic [1:0] RLD_NONE = 2'h0;

   localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h00000000;
   localparam logic [CNT_W-1:0] CNT_RESET = 32'h00000000;
   localparam int FIFO_DEPTH = 4;

   // sources of the 18 defined events, bit n-1 is code n
   typedef struct packed {
      logic serial2_rx;
      logic serial2_tx;
      logic host_to_core_event;
      logic serial1_rx;
      logic serial1_tx;
      logic serial0_rx_event;
      logic serial0_tx_event;
      logic channel3_done;
      logic channel2_done;
      logic channel1_done;
      logic channel0_done_event;
      logic ext_pin7;
      logic ext_pin6;
      logic ext_pin5;
      logic ext_pin4_event;
      logic refresh_timer_event;
      logic timer1_event;
      logic timer0_event;
   } drs_events_type;

   // channel configuration held in the primary and secondary control
   typedef struct packed {
      logic [1:0] run_control;
      logic [1:0] source_reload_select;
      logic [1:0] dest_reload_select;
      logic [1:0] split_mode;
      logic frame_sync_enable;
      logic [4:0] read_event_select;
      logic [4:0] write_event_select;
      logic read_event_polarity;
      logic write_event_polarity;
   } drs_cfg_type;

   // software event manipulation strobes
   typedef struct packed {
      logic read_set;
      logic read_event_clear_bit;
      logic write_set;
      logic write_event_clear_bit;
   } drs_sw_type;

   // completion indications from the data movers
   typedef struct packed {
      logic read_req_done;
      logic write_req_done;
      logic read_frame_end;
      logic write_frame_end;
      logic read_block_end;
      logic write_block_end;
      logic tx_done;
      logic rx_done;
   } drs_done_type;

   // reload register set as a packed word
   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic [ADDR_W-1:0] src;
      logic [ADDR_W-1:0] dst;
   } drs_reload_type;

endpackage : drs_pkg

// [src/drs_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module drs_fifo #(
   parameter int WIDTH = 96,
   parameter int DEPTH = 4
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("fifo depth must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic [AW-1:0] next_wr_ptr;
   logic [AW-1:0] next_rd_ptr;
   logic [AW:0] next_count;
   logic next_ready;
   logic next_valid;
   logic push;
   logic pop;

   always_comb begin
      push = in_valid_i && (count != (AW+1)'(DEPTH));
      pop = out_ready_i && (count != '0);
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count = count + (AW+1)'(push) - (AW+1)'(pop);
      // flags registered from the next count, so they match count exactly
      next_ready = (next_count != (AW+1)'(DEPTH));
      next_valid = (next_count != '0);
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready_o <= 1'b1;
         out_valid_o <= 1'b0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
         in_ready_o <= next_ready;
         out_valid_o <= next_valid;
      end
      if (push)
         mem[wr_ptr] <= in_data_i;
   end

   assign out_data_o = mem[rd_ptr];

   a_fifo_no_over: assert property (@(posedge ref_clk_i)
      disable iff (!reset_n_i) count <= (AW+1)'(DEPTH))
      else $error("fifo count above depth");
endmodule : drs_fifo
`default_nettype wire

// [src/drs_channel.sv]
`timescale 1ns/1ps
`default_nettype none
// How it works
// - counter, source, destination each have reload
// - address reload can be excluded by select
// - block end loads counter from reload, selected addresses only in auto run
// - counter reloads at every frame end
// - read and write side reload separately
// - split mode: tx/rx reloads independent
// - read, write, frame transfers wait events
// - select zero means no synchronization
// - frame sync uses read select only
// - event codes decode to fixed sources
// - selected edge latches pending status flag
// - unselected type reads status as one
// - one event may trigger several latches
// - write one sets or clears, zero ignored
// - clear bits read zero, no storage
// - software manipulation beats hardware set/clear
// - request completion clears read/write flag
// - frame sync clears on first read done
// - polarity bits invert the latched edge
// - run control auto reloads and restarts
module drs_channel
   import drs_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire drs_pkg::drs_events_type events_i,
   input wire drs_pkg::drs_cfg_type cfg_i,
   input wire drs_pkg::drs_sw_type sw_i,
   input wire drs_pkg::drs_done_type done_i,
   input wire logic [drs_pkg::CNT_W-1:0] count_reload_i,
   input wire logic [drs_pkg::ADDR_W-1:0] src_reload_a_i,
   input wire logic [drs_pkg::ADDR_W-1:0] src_reload_b_i,
   input wire logic [drs_pkg::ADDR_W-1:0] dst_reload_a_i,
   input wire logic [drs_pkg::ADDR_W-1:0] dst_reload_b_i,
   input wire logic load_valid_i,
   output logic load_ready_o,
   input wire logic [drs_pkg::CNT_W-1:0] load_count_i,
   input wire logic [drs_pkg::ADDR_W-1:0] load_src_i,
   input wire logic [drs_pkg::ADDR_W-1:0] load_dst_i,
   input wire logic reload_take_i,
   output logic read_go_o,
   output logic write_go_o,
   output logic frame_go_o,
   output logic read_event_pending_o,
   output logic write_event_pending_o,
   output logic read_event_clear_bit_o,
   output logic write_event_clear_bit_o,
   output logic restart_o,
   output logic reload_pending_o,
   output logic [drs_pkg::CNT_W-1:0] read_count_o,
   output logic [drs_pkg::CNT_W-1:0] write_count_o,
   output logic [drs_pkg::ADDR_W-1:0] src_addr_o,
   output logic [drs_pkg::ADDR_W-1:0] dst_addr_o
);
   import drs_pkg::*;

   // pins pass two flops; on-chip event sources arrive on this clock
   logic [3:0] pin_meta;
   logic [3:0] pin_sync;
   logic [EVT_W-1:0] ev_vec;
   logic read_raw;
   logic write_raw;
   logic read_prev;
   logic write_prev;
   logic read_edge;
   logic write_edge;
   logic read_flag;
   logic write_flag;
   logic next_read_flag;
   logic next_write_flag;
   logic first_read;
   logic next_first_read;
   logic read_go;
   logic write_go;
   logic frame_go;
   logic restart;
   logic [CNT_W-1:0] read_count;
   logic [CNT_W-1:0] write_count;
   logic [ADDR_W-1:0] src_addr;
   logic [ADDR_W-1:0] dst_addr;
   logic [CNT_W-1:0] next_read_count;
   logic [CNT_W-1:0] next_write_count;
   logic [ADDR_W-1:0] next_src_addr;
   logic [ADDR_W-1:0] next_dst_addr;
   logic [ADDR_W-1:0] src_reload_sel;
   logic [ADDR_W-1:0] dst_reload_sel;
   logic src_rld_en;
   logic dst_rld_en;
   logic src_reload_ev;
   logic dst_reload_ev;
   drs_reload_type fifo_out;
   logic fifo_valid;

   // event decode; one source may feed both detectors at once
   function automatic logic pick(input logic [EVT_W-1:0] v,
                                 input logic [4:0] sel);
      logic r;
      r = 1'b0;
      if (sel != EVT_NONE && sel <= EVT_LAST)
         r = v[sel - 5'h01];
      return r;
   endfunction : pick

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         pin_meta <= 4'h0;
         pin_sync <= 4'h0;
      end else begin
         pin_meta <= {events_i.ext_pin7, events_i.ext_pin6,
                      events_i.ext_pin5, events_i.ext_pin4_event};
         pin_sync <= pin_meta;
      end
   end
   always_comb begin
      ev_vec = events_i;
      ev_vec[6:3] = pin_sync;
      // polarity xor so an inverted level gives a rising edge on fall
      read_raw = pick(ev_vec, cfg_i.read_event_select)
                 ^ cfg_i.read_event_polarity;
      write_raw = pick(ev_vec, cfg_i.write_event_select)
                  ^ cfg_i.write_event_polarity;
      read_edge = read_raw && !read_prev;
      write_edge = write_raw && !write_prev;
   end

   // software first, then hardware clear, then hardware set
   always_comb begin
      next_read_flag = read_flag;
      next_first_read = first_read;
      if (read_edge)
         next_read_flag = 1'b1;
      if (done_i.read_req_done && (!cfg_i.frame_sync_enable || first_read))
         next_read_flag = 1'b0;
      if (done_i.read_req_done)
         next_first_read = 1'b0;
      if (done_i.read_frame_end)
         next_first_read = 1'b1;
      if (sw_i.read_event_clear_bit)
         next_read_flag = 1'b0;
      else if (sw_i.read_set)
         next_read_flag = 1'b1;
      next_write_flag = write_flag;
      if (write_edge)
         next_write_flag = 1'b1;
      if (done_i.write_req_done)
         next_write_flag = 1'b0;
      if (sw_i.write_event_clear_bit)
         next_write_flag = 1'b0;
      else if (sw_i.write_set)
         next_write_flag = 1'b1;
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         // start from the present level so reset makes no false edge
         read_prev <= read_raw;
         write_prev <= write_raw;
         read_flag <= 1'b0;
         write_flag <= 1'b0;
         first_read <= 1'b1;
      end else begin
         read_prev <= read_raw;
         write_prev <= write_raw;
         read_flag <= next_read_flag;
         write_flag <= next_write_flag;
         first_read <= next_first_read;
      end
   end

   // gating of transfers
   always_comb begin
      if (cfg_i.read_event_select == EVT_NONE) begin
         read_go = 1'b1;
      end else begin
         read_go = read_flag && !cfg_i.frame_sync_enable;
      end
      // frame sync: write side never waits, write select ignored
      if (cfg_i.frame_sync_enable || cfg_i.write_event_select == EVT_NONE)
         write_go = 1'b1;
      else
         write_go = write_flag;
      frame_go = !cfg_i.frame_sync_enable
                 || cfg_i.read_event_select == EVT_NONE
                 || read_flag || !first_read;
   end

   // reload selection; code zero excludes the address from reload
   always_comb begin
      src_rld_en = cfg_i.source_reload_select != RLD_NONE;
      dst_rld_en = cfg_i.dest_reload_select != RLD_NONE;
      src_reload_sel = (cfg_i.source_reload_select == 2'h1) ?
                       src_reload_a_i : src_reload_b_i;
      dst_reload_sel = (cfg_i.dest_reload_select == 2'h1) ?
                       dst_reload_a_i : dst_reload_b_i;
      restart = cfg_i.run_control == RUN_AUTO
                && done_i.read_block_end;
      if (cfg_i.split_mode != 2'h0) begin
         src_reload_ev = done_i.tx_done;
         dst_reload_ev = done_i.rx_done;
      end else begin
         src_reload_ev = done_i.read_block_end;
         dst_reload_ev = done_i.write_block_end;
      end
   end

   // new block parameters queue through the fifo before they run
   drs_fifo #(
      .WIDTH($bits(drs_reload_type)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .in_data_i({load_count_i, load_src_i, load_dst_i}),
      .in_valid_i(load_valid_i),
      .in_ready_o(load_ready_o),
      .out_data_o(fifo_out),
      .out_valid_o(fifo_valid),
      .out_ready_i(reload_take_i)
   );

   always_comb begin
      next_read_count = read_count;
      next_write_count = write_count;
      next_src_addr = src_addr;
      next_dst_addr = dst_addr;
      if (reload_take_i && fifo_valid) begin
         next_read_count = fifo_out.count;
         next_write_count = fifo_out.count;
         next_src_addr = fifo_out.src;
         next_dst_addr = fifo_out.dst;
      end
      if (done_i.read_frame_end || done_i.read_block_end)
         next_read_count = count_reload_i;
      if (done_i.write_frame_end || done_i.write_block_end)
         next_write_count = count_reload_i;
      if (src_reload_ev && src_rld_en && cfg_i.run_control == RUN_AUTO)
         next_src_addr = src_reload_sel;
      if (dst_reload_ev && dst_rld_en && cfg_i.run_control == RUN_AUTO)
         next_dst_addr = dst_reload_sel;
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         read_count <= CNT_RESET;
         write_count <= CNT_RESET;
         src_addr <= ADDR_RESET;
         dst_addr <= ADDR_RESET;
         read_go_o <= 1'b0;
         write_go_o <= 1'b0;
         frame_go_o <= 1'b0;
         read_event_pending_o <= 1'b0;
         write_event_pending_o <= 1'b0;
         restart_o <= 1'b0;
      end else begin
         read_count <= next_read_count;
         write_count <= next_write_count;
         src_addr <= next_src_addr;
         dst_addr <= next_dst_addr;
         read_go_o <= read_go;
         write_go_o <= write_go;
         frame_go_o <= frame_go;
         read_event_pending_o <= (cfg_i.read_event_select == EVT_NONE)
                                 || next_read_flag;
         write_event_pending_o <= (cfg_i.write_event_select == EVT_NONE)
                                  || next_write_flag;
         restart_o <= restart;
      end
   end

   assign read_event_clear_bit_o = 1'b0;
   assign write_event_clear_bit_o = 1'b0;
   assign reload_pending_o = fifo_valid;
   assign read_count_o = read_count;
   assign write_count_o = write_count;
   assign src_addr_o = src_addr;
   assign dst_addr_o = dst_addr;

   a_sw_clear_wins: assert property (@(posedge ref_clk_i)
      disable iff (!reset_n_i)
      sw_i.read_event_clear_bit |=> !read_flag)
      else $error("read clear did not win");
   a_sw_set_wins: assert property (@(posedge ref_clk_i)
      disable iff (!reset_n_i)
      sw_i.write_set && !sw_i.write_event_clear_bit |=> write_flag)
      else $error("write set did not win");
   a_edge_latch: assert property (@(posedge ref_clk_i)
      disable iff (!reset_n_i)
      read_edge && !done_i.read_req_done && !sw_i.read_event_clear_bit
      |=> read_flag)
      else $error("read edge not latched");
   a_write_done_clr: assert property (@(posedge ref_clk_i)
      disable iff (!reset_n_i)
      done_i.write_req_done && !sw_i.write_set |=> !write_flag)
      else $error("write flag not cleared");
   a_none_reads_one: assert property (@(posedge ref_clk_i)
      disable iff (!reset_n_i)
      cfg_i.write_event_select == EVT_NONE |=> write_event_pending_o)
      else $error("unselected status not one");
   a_frame_count: assert property (@(posedge ref_clk_i)
      disable iff (!reset_n_i)
      done_i.read_frame_end |=> read_count == $past(count_reload_i))
      else $error("count not reloaded at frame end");
   a_no_reload_keep: assert property (@(posedge ref_clk_i)
      disable iff (!reset_n_i)
      cfg_i.split_mode == 2'h0 && done_i.read_block_end && !src_rld_en
      && !(reload_take_i && fifo_valid) |=> $stable(src_addr))
      else $error("excluded source reloaded");
   a_auto_restart: assert property (@(posedge ref_clk_i)
      disable iff (!reset_n_i)
      cfg_i.run_control == RUN_AUTO && done_i.read_block_end
      |=> restart_o)
      else $error("restart missing");
   a_fs_write_free: assert property (@(posedge ref_clk_i)
      disable iff (!reset_n_i)
      cfg_i.frame_sync_enable |=> write_go_o)
      else $error("write gated under frame sync");

   c_read_sync: cover property (@(posedge ref_clk_i) read_edge ##1 read_go);
   c_frame_end: cover property (@(posedge ref_clk_i) done_i.read_frame_end);
   c_restart: cover property (@(posedge ref_clk_i) restart_o);
   c_fifo_full: cover property (@(posedge ref_clk_i) !load_ready_o);
endmodule : drs_channel
`default_nettype wire

// [sim/drs_event_model.sv]
`timescale 1ns/1ps
`default_nettype none
// event sources: unrelated sources toggle every cycle, so only the
// selected code may ever latch; the held code follows level_i
module drs_event_model
   import drs_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic [4:0] hold_code_i,
   input wire logic level_i,
   output var drs_pkg::drs_events_type events_o
);
   logic [17:0] noise;
   logic [17:0] lv;
   always_ff @(negedge ref_clk_i) begin
      if (!reset_n_i) begin
         noise <= 18'h2AAAA;
      end else begin
         noise <= ~noise;
      end
   end
   always_comb begin
      lv = noise;
      // reserved codes pick no source at all
      if (hold_code_i != 5'h00 && hold_code_i <= 5'h12) begin
         lv[hold_code_i - 5'h01] = level_i;
      end
      events_o = drs_events_type'(lv);
   end
endmodule : drs_event_model
`default_nettype wire

// [sim/test_dma_channel_reload_and_sync.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin \
 errors++; $display("FAIL %s expected %h seen %h", nm, ex, gt); end end
module test_dma_channel_reload_and_sync;
   import drs_pkg::*;
   logic ref_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   drs_events_type ev;
   drs_cfg_type cfg = '0;
   drs_sw_type sw = '0;
   drs_done_type done = '0;
   logic [CNT_W-1:0] cnt_rl = '0, ld_cnt = '0, rd_cnt, wr_cnt;
   logic [ADDR_W-1:0] sa = '0, sb = '0, da = '0, db = '0;
   logic [ADDR_W-1:0] ld_src = '0, ld_dst = '0, src, dst;
   logic ld_valid = 1'b0, take = 1'b0, ld_ready, pend_ld;
   logic rgo, wgo, fgo, rpend, wpend, rclr, wclr, restart;
   logic [4:0] m_code = 5'h00;
   logic m_level = 1'b0;
   int errors = 0, n_checks = 0, restart_cnt = 0;

   always #50 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) if (restart === 1'b1) restart_cnt++;

   drs_event_model i_model (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
      .hold_code_i(m_code), .level_i(m_level), .events_o(ev));

   drs_channel i_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
      .events_i(ev), .cfg_i(cfg), .sw_i(sw), .done_i(done),
      .count_reload_i(cnt_rl), .src_reload_a_i(sa), .src_reload_b_i(sb),
      .dst_reload_a_i(da), .dst_reload_b_i(db), .load_valid_i(ld_valid),
      .load_ready_o(ld_ready), .load_count_i(ld_cnt), .load_src_i(ld_src),
      .load_dst_i(ld_dst), .reload_take_i(take), .read_go_o(rgo),
      .write_go_o(wgo), .frame_go_o(fgo), .read_event_pending_o(rpend),
      .write_event_pending_o(wpend), .read_event_clear_bit_o(rclr),
      .write_event_clear_bit_o(wclr), .restart_o(restart),
      .reload_pending_o(pend_ld), .read_count_o(rd_cnt),
      .write_count_o(wr_cnt), .src_addr_o(src), .dst_addr_o(dst));

   task cyc(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask : cyc

   // strobes are one-cycle pulses; clr_both drives both clear fields at once
   task clr_both();
      sw.read_event_clear_bit = 1'b1;
      sw.write_event_clear_bit = 1'b1;
      cyc(1);
      sw = '0;
   endtask : clr_both

   task t_reset();
      `CHK("read pending unselected", 1'b1, rpend)
      `CHK("write pending unselected", 1'b1, wpend)
      `CHK("read go unsynced", 1'b1, rgo)
      `CHK("write go unsynced", 1'b1, wgo)
      `CHK("read clear bit", 1'b0, rclr)
      `CHK("write clear bit", 1'b0, wclr)
      `CHK("source after reset", ADDR_RESET, src)
      `CHK("reload queue empty", 1'b0, pend_ld)
   endtask : t_reset

   task t_decode();
      for (int c = 1; c <= 31; c++) begin
         m_code = c[4:0];
         m_level = 1'b0;
         cfg.read_event_select = c[4:0];
         cfg.write_event_select = c[4:0];
         cyc(6);
         clr_both();
         cyc(6);
         `CHK("read pending idle", 1'b0, rpend)
         if (c <= 18) begin
            m_level = 1'b1;
            cyc(6);
            `CHK("read pending", 1'b1, rpend)
            `CHK("write pending", 1'b1, wpend)
            `CHK("write go", 1'b1, wgo)
            `CHK("read go", 1'b1, rgo)
            done.read_req_done = 1'b1;
            cyc(1);
            done = '0;
            cyc(3);
            `CHK("read after done", 1'b0, rpend)
            `CHK("read go off", 1'b0, rgo)
            `CHK("write kept", 1'b1, wpend)
            done.write_req_done = 1'b1;
            cyc(1);
            done = '0;
            cyc(3);
            `CHK("write after done", 1'b0, wpend)
            `CHK("write go off", 1'b0, wgo)
         end
      end
   endtask : t_decode

   task t_polarity();
      m_code = EVT_PIN4;
      m_level = 1'b1;
      cfg.read_event_select = EVT_PIN4;
      cfg.write_event_select = EVT_PIN4;
      cfg.read_event_polarity = 1'b1;
      cyc(8);
      clr_both();
      cyc(8);
      m_level = 1'b0;
      cyc(8);
      `CHK("read falling edge", 1'b1, rpend)
      `CHK("write ignores fall", 1'b0, wpend)
      m_level = 1'b1;
      cyc(8);
      `CHK("write rising edge", 1'b1, wpend)
      cfg.read_event_polarity = 1'b0;
   endtask : t_polarity

   task t_priority();
      m_code = EVT_TIMER0;
      m_level = 1'b0;
      cfg.read_event_select = EVT_TIMER0;
      cfg.write_event_select = EVT_TIMER0;
      cyc(4);
      clr_both();
      cyc(3);
      sw.read_set = 1'b1;
      cyc(1);
      sw = '0;
      cyc(2);
      `CHK("software set", 1'b1, rpend)
      `CHK("other flag untouched", 1'b0, wpend)
      sw.read_set = 1'b1;
      done.read_req_done = 1'b1;
      cyc(1);
      sw = '0;
      done = '0;
      cyc(2);
      `CHK("set beats hw clear", 1'b1, rpend)
      sw.read_event_clear_bit = 1'b1;
      cyc(1);
      sw = '0;
      cyc(2);
      `CHK("software clear", 1'b0, rpend)
   endtask : t_priority

   task pulse_rd_done();
      done.read_req_done = 1'b1;
      cyc(1);
      done = '0;
      cyc(3);
   endtask : pulse_rd_done

   task t_frame();
      cfg.frame_sync_enable = 1'b1;
      cfg.write_event_select = EVT_NONE;
      cfg.read_event_select = EVT_TIMER1;
      m_code = EVT_TIMER1;
      m_level = 1'b0;
      done.read_frame_end = 1'b1;
      cyc(1);
      done = '0;
      cyc(4);
      clr_both();
      cyc(3);
      `CHK("frame waits", 1'b0, fgo)
      m_level = 1'b1;
      cyc(4);
      `CHK("frame event", 1'b1, rpend)
      `CHK("frame go", 1'b1, fgo)
      `CHK("write free", 1'b1, wgo)
      pulse_rd_done();
      `CHK("first read clears", 1'b0, rpend)
      sw.read_set = 1'b1;
      cyc(1);
      sw = '0;
      cyc(2);
      pulse_rd_done();
      `CHK("later read keeps", 1'b1, rpend)
      done.read_frame_end = 1'b1;
      cyc(1);
      done = '0;
      pulse_rd_done();
      `CHK("new frame clears", 1'b0, rpend)
      cfg.frame_sync_enable = 1'b0;
   endtask : t_frame

   task pulse_done(input drs_done_type v);
      done = v;
      cyc(1);
      done = '0;
      cyc(2);
   endtask : pulse_done

   task t_reload();
      drs_done_type d;
      cnt_rl = 32'h00000010;
      sa = 32'h10000000;
      sb = 32'h20000000;
      da = 32'h30000000;
      db = 32'h40000000;
      cfg.run_control = RUN_AUTO;
      cfg.source_reload_select = 2'h1;
      cfg.dest_reload_select = 2'h2;
      d = '0;
      d.read_block_end = 1'b1;
      pulse_done(d);
      `CHK("source reloaded", 32'h10000000, src)
      `CHK("read count", 32'h00000010, rd_cnt)
      `CHK("dest waits", ADDR_RESET, dst)
      d = '0;
      d.write_block_end = 1'b1;
      pulse_done(d);
      `CHK("dest reloaded", 32'h40000000, dst)
      `CHK("restart", 1'b1, restart_cnt != 0)
      // addresses stay in one space across reloads
      cfg.source_reload_select = RLD_NONE;
      sa = 32'h11110000;
      db = 32'h40000100;
      d.read_block_end = 1'b1;
      pulse_done(d);
      `CHK("source excluded", 32'h10000000, src)
      `CHK("dest second block", 32'h40000100, dst)
      cfg.run_control = RUN_STOP;
      cnt_rl = 32'h00000020;
      db = 32'h40000200;
      d = '0;
      d.read_frame_end = 1'b1;
      pulse_done(d);
      `CHK("frame count", 32'h00000020, rd_cnt)
      `CHK("write count waits", 32'h00000010, wr_cnt)
      d = '0;
      d.write_frame_end = 1'b1;
      pulse_done(d);
      `CHK("write frame count", 32'h00000020, wr_cnt)
      d.write_block_end = 1'b1;
      pulse_done(d);
      `CHK("no address reload", 32'h40000100, dst)
      cfg.run_control = RUN_AUTO;
      cfg.split_mode = 2'h1;
      cfg.read_event_select = EVT_TIMER0;
      cfg.write_event_select = EVT_TIMER1;
      cfg.source_reload_select = 2'h1;
      sa = 32'h10000040;
      db = 32'h40000300;
      d = '0;
      d.tx_done = 1'b1;
      pulse_done(d);
      `CHK("tx source", 32'h10000040, src)
      `CHK("tx leaves dest", 32'h40000100, dst)
      d = '0;
      d.rx_done = 1'b1;
      pulse_done(d);
      `CHK("rx dest", 32'h40000300, dst)
      cfg.split_mode = 2'h0;
      cfg.run_control = RUN_STOP;
   endtask : t_reload

   task t_fifo();
      for (int i = 0; i <= FIFO_DEPTH; i++) begin
         ld_cnt = i;
         ld_src = 32'h50000000 + i;
         ld_dst = 32'h60000000 + i;
         ld_valid = 1'b1;
         cyc(1);
      end
      `CHK("queue full", 1'b0, ld_ready)
      ld_valid = 1'b0;
      cyc(3);
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         `CHK("queue not empty", 1'b1, pend_ld)
         take = 1'b1;
         cyc(1);
         take = 1'b0;
         cyc(2);
         `CHK("queued source", 32'h50000000 + i, src)
         `CHK("queued dest", 32'h60000000 + i, dst)
      end
      `CHK("queue drained", 1'b0, pend_ld)
      `CHK("queue ready", 1'b1, ld_ready)
   endtask : t_fifo

   task report_and_stop();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      #2000000;
      errors++;
      $display("FAIL watchdog expected end seen hang");
      report_and_stop();
   end

   initial begin
      repeat (10) @(negedge ref_clk_i);
      reset_n_i = 1'b1;
      cyc(2);
      t_reset();
      t_decode();
      t_polarity();
      t_priority();
      t_frame();
      t_reload();
      t_fifo();
      report_and_stop();
   end
endmodule : test_dma_channel_reload_and_sync
`default_nettype wire
